// ==== inc/idu_pkg.sv ====
// Shared constants and types of the two-wire converter update slave
package idu_pkg;

  // ----------------------------------------
  // Bus framing
  // ----------------------------------------
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [5:0] ADDR_FIXED   = 6'h26;
  localparam logic [7:0] ADDR_BCAST   = 8'h90;
  localparam logic [4:0] HS_CODE_TOP  = 5'h01;
  localparam logic [1:0] SEL_WAIT     = 2'h3;
  localparam int         SCL_PERIOD_NS = 125;

  // ----------------------------------------
  // Power-down codes
  // ----------------------------------------
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K     = 2'h1;
  localparam logic [1:0] PD_100K   = 2'h2;
  localparam logic [1:0] PD_HIZ    = 2'h3;

  // ----------------------------------------
  // Buffer shape
  // ----------------------------------------
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_CTRL     = 3'b010,
    ST_LOW      = 3'b011,
    ST_ACK      = 3'b100
  } idu_state_t;

  typedef struct packed {
    logic [1:0] pd;
    logic [9:0] code;
  } idu_update_t;

  typedef struct packed {
    logic amp_on;
    logic gnd_1k;
    logic gnd_100k;
    logic hiz;
    logic linear_on;
  } idu_stage_t;

  localparam idu_stage_t STAGE_NORMAL = 5'h11;

endpackage

// ==== rtl/idu_slave.sv ====
// Two-wire slave that loads a 10-bit converter code and power-down mode
//
// Overview of operation
// - Each byte of a matched write is acknowledged by SDA low one clock; a low byte only while the update buffer has room.
// - Control byte: two zeros, two power-down bits, four top code bits.
// - Low byte gives six low code bits up top; two lowest bits ignored.
// - Code and mode load on falling edge of the low byte acknowledge.
// - Further byte pairs in one transfer update without new start.
// - Each repeated update completes within 18 bus clocks.
// - After a stop the bus is released and traffic ignored till start.
// - Address 100110, select bit, then write direction bit zero.
// - Select bit is latched from its pin at power-up and kept.
// - Broadcast address 1001_0000 is accepted whatever the select pin.
// - Power-up clears the code to zero until a valid write.
// - Modes: 00 normal, 01 1k, 10 100k, 11 high impedance.
// - Power-down switches output to termination, linear circuits off.
// - Stored code still loads from each write made while powered down.
// - High-speed master code is not acknowledged; stop ends fast mode.
// - Only 7-bit slave addressing; no 10-bit, no general call.
`timescale 1ns/100ps

// ----------------------------------------
// Update buffer
// ----------------------------------------
module idu_fifo
  import idu_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,     // System clock
  input  wire logic             reset_n,   // Synchronous reset
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Write word
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Reader takes word
  output logic      [WIDTH-1:0] out_data   // Head word
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wr_ptr;
    logic [PW:0]                 rd_ptr;
  } idu_fifo_st_t;

  idu_fifo_st_t st_ff;
  idu_fifo_st_t nxt_st;
  logic         full;
  logic         empty;

  assign full      = (st_ff.wr_ptr[PW] != st_ff.rd_ptr[PW])
                  && (st_ff.wr_ptr[PW-1:0] == st_ff.rd_ptr[PW-1:0]);
  assign empty     = (st_ff.wr_ptr == st_ff.rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_ff.mem[st_ff.rd_ptr[PW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) begin
      nxt_st.mem[st_ff.wr_ptr[PW-1:0]] = in_data;
      nxt_st.wr_ptr = st_ff.wr_ptr + (PW+1)'(1);
    end
    if (out_ready && !empty) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + (PW+1)'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ----------------------------------------
// Bus slave and conversion register
// ----------------------------------------
module idu_slave
  import idu_pkg::*;
(
  input  wire logic  clock,                  // System clock, 125 MHz
  input  wire logic  reset_n,                // Synchronous reset
  input  wire logic  scl_in,                 // Bus clock pin
  input  wire logic  sda_in,                 // Bus data pin level
  output logic       sda_out,                // Data drive value
  output logic       sda_oe,                 // Data drive enable
  input  wire logic  address_select_pin,     // Address select strap
  output logic [9:0] conversion_code_bits,   // Active code
  output logic       powerdown_select_high,  // Active mode bit 1
  output logic       powerdown_select_low,   // Active mode bit 0
  output logic       powered_down,           // Any power-down mode
  output idu_stage_t out_stage,              // Output stage switches
  output logic       hs_mode,                // High-speed setting
  output logic       address_select_latched, // Captured select bit
  output logic       upd_valid,              // Update stream valid
  input  wire logic  upd_ready,              // Update stream ready
  output idu_update_t upd_data               // Update stream word
);

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_s3;
    logic        sel_s1;
    logic        sel_s2;
    logic [1:0]  sel_cnt;
    logic        sel_bit;
    idu_state_t  fsm;
    idu_state_t  after_ack;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [1:0]  pend_pd;
    logic [3:0]  pend_msb;
    logic        load_pend;
    logic        ack_oe;
    logic        hs;
    idu_update_t active;
    idu_stage_t  stage;
    logic        push;
  } idu_slave_st_t;

  idu_slave_st_t st_ff;
  idu_slave_st_t nxt_st;
  logic          fifo_ready;
  logic          scl_rise;
  logic          scl_fall;
  logic          bus_start;
  logic          bus_stop;

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  function automatic logic addr_match(input logic [7:0] b, input logic sel);
    logic own;
    logic bcast;
    own   = (b[7:2] == ADDR_FIXED) && (b[1] == sel) && !b[0];
    bcast = (b == ADDR_BCAST);
    return own || bcast;
  endfunction

  function automatic idu_stage_t stage_of(input logic [1:0] pd);
    idu_stage_t s;
    s = '0;
    unique case (pd)
      PD_NORMAL: begin
        s.amp_on    = 1'b1;
        s.linear_on = 1'b1;
      end
      PD_1K: begin
        s.gnd_1k = 1'b1;
      end
      PD_100K: begin
        s.gnd_100k = 1'b1;
      end
      PD_HIZ: begin
        s.hiz = 1'b1;
      end
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // Bus events
  // ----------------------------------------
  assign scl_rise  = st_ff.scl_s2 && !st_ff.scl_s3;
  assign scl_fall  = !st_ff.scl_s2 && st_ff.scl_s3;
  assign bus_start = st_ff.scl_s2 && st_ff.scl_s3
                  && !st_ff.sda_s2 && st_ff.sda_s3;
  assign bus_stop  = st_ff.scl_s2 && st_ff.scl_s3
                  && st_ff.sda_s2 && !st_ff.sda_s3;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.push   = 1'b0;
    nxt_st.scl_s1 = scl_in;
    nxt_st.scl_s2 = st_ff.scl_s1;
    nxt_st.scl_s3 = st_ff.scl_s2;
    nxt_st.sda_s1 = sda_in;
    nxt_st.sda_s2 = st_ff.sda_s1;
    nxt_st.sda_s3 = st_ff.sda_s2;
    nxt_st.sel_s1 = address_select_pin;
    nxt_st.sel_s2 = st_ff.sel_s1;

    if (st_ff.sel_cnt < SEL_WAIT) begin
      nxt_st.sel_cnt = 2'(st_ff.sel_cnt + 2'h1);
      nxt_st.sel_bit = st_ff.sel_s2;
    end

    if (bus_stop) begin
      nxt_st.fsm       = ST_IDLE;
      nxt_st.ack_oe    = 1'b0;
      nxt_st.load_pend = 1'b0;
      nxt_st.hs        = 1'b0;
    end else if (bus_start) begin
      nxt_st.fsm       = ST_ADDR;
      nxt_st.bit_cnt   = '0;
      nxt_st.ack_oe    = 1'b0;
      nxt_st.load_pend = 1'b0;
    end else begin
      unique case (st_ff.fsm)
        ST_IDLE: begin
          nxt_st.ack_oe = 1'b0;
        end
        ST_ADDR, ST_CTRL, ST_LOW: begin
          if (scl_rise && st_ff.bit_cnt < BYTE_BITS) begin
            nxt_st.shreg   = {st_ff.shreg[6:0], st_ff.sda_s2};
            nxt_st.bit_cnt = 4'(st_ff.bit_cnt + 4'h1);
          end
          if (scl_fall && st_ff.bit_cnt == BYTE_BITS) begin
            nxt_st.bit_cnt = '0;
            if (st_ff.fsm == ST_ADDR) begin
              if (st_ff.shreg[7:3] == HS_CODE_TOP) begin
                nxt_st.hs  = 1'b1;
                nxt_st.fsm = ST_IDLE;
              end else if (addr_match(st_ff.shreg, st_ff.sel_bit)) begin
                nxt_st.ack_oe    = 1'b1;
                nxt_st.fsm       = ST_ACK;
                nxt_st.after_ack = ST_CTRL;
              end else begin
                nxt_st.fsm = ST_IDLE;
              end
            end else if (st_ff.fsm == ST_CTRL) begin
              nxt_st.pend_pd   = st_ff.shreg[5:4];
              nxt_st.pend_msb  = st_ff.shreg[3:0];
              nxt_st.ack_oe    = 1'b1;
              nxt_st.fsm       = ST_ACK;
              nxt_st.after_ack = ST_LOW;
            end else if (fifo_ready) begin
              nxt_st.ack_oe    = 1'b1;
              nxt_st.load_pend = 1'b1;
              nxt_st.fsm       = ST_ACK;
              nxt_st.after_ack = ST_CTRL;
            end else begin
              nxt_st.fsm = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_st.ack_oe  = 1'b0;
            nxt_st.fsm     = st_ff.after_ack;
            nxt_st.bit_cnt = '0;
            if (st_ff.load_pend) begin
              nxt_st.active.code = {st_ff.pend_msb, st_ff.shreg[7:2]};
              nxt_st.active.pd   = st_ff.pend_pd;
              nxt_st.stage       = stage_of(st_ff.pend_pd);
              nxt_st.push        = 1'b1;
              nxt_st.load_pend   = 1'b0;
            end
          end
        end
        default: begin
          nxt_st.fsm    = ST_IDLE;
          nxt_st.ack_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_ff        <= '0;
      st_ff.stage  <= STAGE_NORMAL;
      // Pin stages start at the idle bus level, so no false edge after reset
      st_ff.scl_s1 <= 1'b1;
      st_ff.scl_s2 <= 1'b1;
      st_ff.scl_s3 <= 1'b1;
      st_ff.sda_s1 <= 1'b1;
      st_ff.sda_s2 <= 1'b1;
      st_ff.sda_s3 <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Update stream buffer
  // ----------------------------------------
  idu_fifo #(
    .WIDTH ($bits(idu_update_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (st_ff.push),
    .in_ready  (fifo_ready),
    .in_data   (st_ff.active),
    .out_valid (upd_valid),
    .out_ready (upd_ready),
    .out_data  (upd_data)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sda_out                = 1'b0;
  assign sda_oe                 = st_ff.ack_oe;
  assign conversion_code_bits   = st_ff.active.code;
  assign powerdown_select_high  = st_ff.active.pd[1];
  assign powerdown_select_low   = st_ff.active.pd[0];
  assign powered_down           = !st_ff.stage.amp_on;
  assign out_stage              = st_ff.stage;
  assign hs_mode                = st_ff.hs;
  assign address_select_latched = st_ff.sel_bit;

endmodule

// ==== tb/idu_slave_sva.sv ====
// Assertion checker of the converter update slave
`timescale 1ns/100ps
module idu_slave_sva
  import idu_pkg::*;
(
  input wire logic       clock,                  // System clock
  input wire logic       reset_n,                // Sync reset
  input wire logic       scl_in,                 // Bus clock pin
  input wire logic       sda_in,                 // Data wire
  input wire logic       sda_out,                // Drive value
  input wire logic       sda_oe,                 // Drive enable
  input wire logic [9:0] conversion_code_bits,   // Active code
  input wire logic       powerdown_select_high,  // Mode bit 1
  input wire logic       powerdown_select_low,   // Mode bit 0
  input wire logic       powered_down,           // Power-down flag
  input wire idu_stage_t out_stage,              // Stage switches
  input wire logic       hs_mode,                // Fast mode
  input wire logic       address_select_latched, // Select bit
  input wire logic       upd_valid               // Stream valid
);
  logic [2:0] age_ff;
  logic [2:0] nxt_age;
  logic [1:0] mode;
  assign mode = {powerdown_select_high, powerdown_select_low};
  always_comb nxt_age = (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
  always_ff @(posedge clock) age_ff <= reset_n ? nxt_age : 3'h0;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rst;
    disable iff (1'h0) !reset_n |=> conversion_code_bits == 10'h000 && !powered_down && !sda_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hold;
    $changed({mode, conversion_code_bits}) |-> $fell(sda_oe);
  endproperty
  a_hold: assert property (p_hold) else $error("load off ack end");
  property p_push;
    $changed({mode, conversion_code_bits}) |=> upd_valid;
  endproperty
  a_push: assert property (p_push) else $error("load not queued");
  property p_ack_len;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack too short");
  property p_ack_scl;
    ($rose(sda_oe) || $fell(sda_oe)) |-> !scl_in && !sda_out;
  endproperty
  a_ack_scl: assert property (p_ack_scl) else $error("ack edge in high");
  property p_stop;
    (scl_in && $rose(sda_in)) |-> ##6 (!sda_oe && !hs_mode);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");
  property p_pd;
    powered_down == (mode != 2'h0);
  endproperty
  a_pd: assert property (p_pd) else $error("flag wrong");
  property p_stage;
    out_stage == (mode == 2'h0 ? 5'h11 : mode == 2'h1 ? 5'h08 : mode == 2'h2 ? 5'h04 : 5'h02);
  endproperty
  a_stage: assert property (p_stage) else $error("stage wrong");
  property p_sel;
    age_ff == 3'h7 |-> $stable(address_select_latched);
  endproperty
  a_sel: assert property (p_sel) else $error("select moved");
endmodule

bind idu_slave idu_slave_sva i_sva (
  .clock(clock), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .conversion_code_bits(conversion_code_bits),
  .powerdown_select_high(powerdown_select_high), .powerdown_select_low(powerdown_select_low),
  .powered_down(powered_down), .out_stage(out_stage), .hs_mode(hs_mode),
  .address_select_latched(address_select_latched), .upd_valid(upd_valid)
);

// ==== tb/idu_master_model.sv ====
// Two-wire bus master model writing update bytes
`timescale 1ns/100ps
module idu_master_model (
  output logic      scl,     // Bus clock drive
  output logic      sda,     // Data drive, 1 releases to pull-up
  input  wire logic sda_line // Resolved data wire
);
  // Quarters split unevenly so the bus period stays 125 ns at 100 ps steps
  localparam realtime H = 62.5;
  localparam realtime Q = 31.2;
  localparam realtime R = H - Q;
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task automatic start();
    sda = 1'h1;
    #Q scl = 1'h1;
    #H sda = 1'h0;
    #H scl = 1'h0;
    #R;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda = b[i];
      #Q scl = 1'h1;
      #H scl = 1'h0;
      #R;
    end
    sda = 1'h1;
    #Q scl = 1'h1;
    #Q ack = !sda_line;
    #R scl = 1'h0;
    #R;
  endtask
  task automatic stop();
    sda = 1'h0;
    #Q scl = 1'h1;
    #H sda = 1'h1;
    #H;
  endtask
endmodule

// ==== tb/idu_slave_bench.sv ====
// Self-checking bench of the converter update slave
`timescale 1ns/100ps
module idu_slave_bench
  import idu_pkg::*;
;
  logic        clock = 1'h0;
  logic        reset_n = 1'h0;
  logic        address_select_pin = 1'h1;
  logic        upd_ready = 1'h0;
  logic        scl;
  logic        m_sda;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic [9:0]  conversion_code_bits;
  logic        pd_hi;
  logic        pd_lo;
  logic        powered_down;
  idu_stage_t  out_stage;
  logic        hs_mode;
  logic        sel_bit;
  logic        upd_valid;
  idu_update_t upd_data;
  idu_update_t cur = '0;
  idu_update_t exp_q[$];
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;

  assign sda_line = m_sda & ~(sda_oe & ~sda_out);
  always #4 clock = ~clock;
  idu_slave i_dut (
    .clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_pin(address_select_pin),
    .conversion_code_bits(conversion_code_bits), .powerdown_select_high(pd_hi),
    .powerdown_select_low(pd_lo), .powered_down(powered_down), .out_stage(out_stage),
    .hs_mode(hs_mode), .address_select_latched(sel_bit), .upd_valid(upd_valid),
    .upd_ready(upd_ready), .upd_data(upd_data)
  );
  idu_master_model i_mst (.scl(scl), .sda(m_sda), .sda_line(sda_line));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic idu_stage_t stage_of(input logic [1:0] pd);
    return pd == 2'h0 ? 5'h11 : pd == 2'h1 ? 5'h08 : pd == 2'h2 ? 5'h04 : 5'h02;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ack bit 1 for control byte, bit 0 for low byte
  task automatic send_pair(input logic [1:0] pd, input logic [9:0] code, input logic [1:0] ok);
    logic a;
    i_mst.put_byte({2'h0, pd, code[9:6]}, a);
    check("ctrl ack", 16'(a), 16'(ok[1]));
    i_mst.put_byte({code[5:0], 2'h3}, a);
    check("low ack", 16'(a), 16'(ok[0]));
    if (ok[0]) begin
      cur = {pd, code};
      exp_q.push_back(cur);
    end
    repeat (2) @(negedge clock);
    check("code", 16'(conversion_code_bits), 16'(cur.code));
    check("mode", 16'({pd_hi, pd_lo}), 16'(cur.pd));
    check("stage", 16'(out_stage), 16'(stage_of(cur.pd)));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    repeat (5) @(negedge clock);
    check("zero", 16'({conversion_code_bits, pd_hi, pd_lo, upd_valid}), 16'h0000);
    check("stage0", 16'(out_stage), 16'h0011);
    check("select", 16'(sel_bit), 16'h0001);
    address_select_pin = 1'h0;
  endtask
  task automatic t_refuse();
    logic [7:0] bad[5] = '{8'h98, 8'h9B, 8'h00, 8'hF2, 8'h09};
    logic       a;
    foreach (bad[i]) begin
      i_mst.start();
      i_mst.put_byte(bad[i], a);
      check("addr ack", 16'(a), 16'h0000);
      check("fast", 16'(hs_mode), 16'(bad[i] == 8'h09));
      send_pair(2'h1, 10'h3FF, 2'h0);
      i_mst.stop();
      repeat (2) @(negedge clock);
      check("fast end", 16'(hs_mode), 16'h0000);
    end
  endtask
  task automatic t_update();
    logic [9:0] codes[4] = '{10'h3FF, 10'h000, 10'h2AA, 10'h155};
    logic       a;
    i_mst.start();
    i_mst.put_byte(8'h9A, a);
    check("own ack", 16'(a), 16'h0001);
    for (int m = 0; m < 4; m++) begin
      send_pair(2'(m), codes[m], 2'h3);
      check("pd flag", 16'(powered_down), 16'(m != 0));
      check("18 clocks", 16'(conversion_code_bits), 16'(codes[m]));
    end
    check("pd code", 16'(conversion_code_bits), 16'h0155);
    i_mst.put_byte(8'h0F, a);
    check("ctrl only ack", 16'(a), 16'h0001);
    i_mst.stop();
    repeat (2) @(negedge clock);
    check("cut", 16'(conversion_code_bits), 16'(cur.code));
    i_mst.start();
    i_mst.put_byte(8'h90, a);
    check("bcast ack", 16'(a), 16'h0001);
    send_pair(2'h0, 10'h201, 2'h3);
    i_mst.stop();
  endtask
  task automatic t_fill();
    logic a;
    i_mst.start();
    i_mst.put_byte(8'h9A, a);
    while (exp_q.size() < FIFO_DEPTH) send_pair(2'h2, 10'(exp_q.size() * 37), 2'h3);
    send_pair(2'h1, 10'h0F0, 2'h2);
    i_mst.stop();
    @(negedge clock);
    upd_ready = 1'h1;
    while (exp_q.size() > 0) begin
      check("head", 16'({upd_valid, upd_data}), 16'({1'h1, exp_q.pop_front()}));
      @(negedge clock);
    end
    check("empty", 16'(upd_valid), 16'h0000);
    upd_ready = 1'h0;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(negedge clock);
    reset_n = 1'h1;
    t_reset();
    t_refuse();
    t_update();
    t_fill();
    stop_test();
  end
endmodule
